//--- logic/opfm_map.vh
// register offsets, field positions, reset values and pin drive codes of the output pin mux
`ifndef OPFM_MAP_VH
`define OPFM_MAP_VH

// register byte offsets on the apb bus
`define OPFM_FSEL_OFS 8'h00
`define OPFM_SET_OFS 8'h04
`define OPFM_CLR_OFS 8'h08
`define OPFM_LATCH_OFS 8'h0C
`define OPFM_PIN_OFS 8'h10
`define OPFM_SRC_OFS 8'h14

// function select fields
`define OPFM_FSEL_P7 7
`define OPFM_FSEL_P6 6
`define OPFM_FSEL_P5 5
`define OPFM_FSEL_P4 4
`define OPFM_FSEL_P3_HI 3
`define OPFM_FSEL_P3_LO 2
`define OPFM_FSEL_P2_HI 1
`define OPFM_FSEL_P2_LO 0

// pin 3 and pin 2 source codes
`define OPFM_SRC_LATCH 2'h0
`define OPFM_SRC_ALT1 2'h1
`define OPFM_SRC_ALT2 2'h2
`define OPFM_SRC_ALT3 2'h3

// channel mode bits that enable the send request pins
`define OPFM_MODE_FIRST_RTS_BIT 7
`define OPFM_MODE_SECOND_RTS_BIT 5

// reset values
`define OPFM_FSEL_RST 8'h00
`define OPFM_LATCH_RST 8'h00

// pin drive kinds
`define OPFM_DRV_LATCH 2'h0
`define OPFM_DRV_PUSH 2'h1
`define OPFM_DRV_OPEN 2'h2

// pins that survive on the reduced-pin variant
`define OPFM_REDUCED_MASK 8'h03

`endif

//--- logic/opfm_pin_drive.v
// one output pin: registered level and output enable for latch, push-pull or open-drain use
`timescale 1ns/1ps
`include "opfm_map.vh"

module opfm_pin_drive (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // source selection
  input wire [1:0] drive_kind,
  input wire latch_bit,
  input wire alt_bit,
  input wire pin_exists,
  // pin
  output reg pin_out,
  output reg pin_oe
);

  reg pin_out_next;
  reg pin_oe_next;

  // choose level and enable for the selected kind
  always @* begin
    pin_out_next = 1'b0;
    pin_oe_next = 1'b0;
    if (pin_exists) begin
      case (drive_kind)
        `OPFM_DRV_LATCH: begin
          pin_out_next = ~latch_bit;
          pin_oe_next = 1'b1;
        end
        `OPFM_DRV_PUSH: begin
          pin_out_next = alt_bit;
          pin_oe_next = 1'b1;
        end
        `OPFM_DRV_OPEN: begin
          pin_out_next = 1'b0; // asserted status pulls low, else released
          pin_oe_next = alt_bit;
        end
        default: begin
          pin_out_next = ~latch_bit;
          pin_oe_next = 1'b1;
        end
      endcase
    end
  end

  // pin flops; reset shows a driven high level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b1;
      pin_oe <= 1'b1;
    end else begin
      pin_out <= pin_out_next;
      pin_oe <= pin_oe_next;
    end
  end

endmodule

//--- logic/opfm_mux.v
// output port function mux: latch, function select, apb slave and eight pin drivers
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "opfm_map.vh"

module opfm_mux #(
  parameter REDUCED_PINS = 0,
  parameter ADDR_W = 8
) (
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // channel a sources
  input wire chan_a_send_request_n,
  input wire chan_a_mode_first_b7,
  input wire chan_a_mode_second_b5,
  input wire chan_a_tx_ready,
  input wire chan_a_rx_ready_or_full,
  input wire chan_a_tx_clock_16x,
  input wire chan_a_tx_bit_clock,
  input wire chan_a_rx_bit_clock,
  // channel b sources
  input wire chan_b_send_request_n,
  input wire chan_b_mode_first_b7,
  input wire chan_b_mode_second_b5,
  input wire chan_b_tx_ready,
  input wire chan_b_rx_ready_or_full,
  input wire chan_b_tx_bit_clock,
  input wire chan_b_rx_bit_clock,
  // counter/timer source
  input wire ctr_timer_ready,
  // output pins, bit n is output_pin_n
  output wire [7:0] output_pin,
  output wire [7:0] output_pin_oe
);

  // pins that exist on this variant
  localparam [7:0] PIN_MASK = (REDUCED_PINS != 0) ? `OPFM_REDUCED_MASK : 8'hFF;

  // bus phase decode
  wire bus_setup;
  wire bus_access;
  wire bus_wr;
  wire [7:0] reg_ofs;
  wire ofs_known;

  // register state
  reg [7:0] output_pin_function_select_reg;
  reg [7:0] output_pin_function_select_next;
  reg [7:0] output_pin_latch_reg;
  reg [7:0] output_pin_latch_next;

  // per pin selection
  reg [15:0] pin_kind;
  reg [7:0] pin_alt;
  wire [7:0] fsel_eff;
  wire rts_a_on;
  wire rts_b_on;

  // read data path
  reg [31:0] rdata_next;

  // apb phase and address decode
  assign bus_setup = psel & ~penable;
  assign bus_access = psel & penable;
  assign bus_wr = bus_access & pwrite;
  assign reg_ofs = paddr[7:0];
  assign ofs_known = (reg_ofs == `OPFM_FSEL_OFS) |
                     (reg_ofs == `OPFM_SET_OFS) |
                     (reg_ofs == `OPFM_CLR_OFS) |
                     (reg_ofs == `OPFM_LATCH_OFS) |
                     (reg_ofs == `OPFM_PIN_OFS) |
                     (reg_ofs == `OPFM_SRC_OFS);

  // zero wait state slave; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = bus_access & ~ofs_known;

  // function select write, ignored on the reduced variant
  always @* begin
    output_pin_function_select_next = output_pin_function_select_reg;
    if (bus_wr && (reg_ofs == `OPFM_FSEL_OFS) && (REDUCED_PINS == 0)) begin
      output_pin_function_select_next = pwdata[7:0];
    end
  end

  // latch set and clear commands
  always @* begin
    output_pin_latch_next = output_pin_latch_reg;
    if (bus_wr && (reg_ofs == `OPFM_SET_OFS)) begin
      output_pin_latch_next = output_pin_latch_reg | (pwdata[7:0] & PIN_MASK);
    end else if (bus_wr && (reg_ofs == `OPFM_CLR_OFS)) begin
      output_pin_latch_next = output_pin_latch_reg & ~(pwdata[7:0] & PIN_MASK);
    end
  end

  // register flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_pin_function_select_reg <= `OPFM_FSEL_RST;
      output_pin_latch_reg <= `OPFM_LATCH_RST;
    end else begin
      output_pin_function_select_reg <= output_pin_function_select_next;
      output_pin_latch_reg <= output_pin_latch_next;
    end
  end

  // selection only counts for pins that exist
  assign fsel_eff = output_pin_function_select_reg & PIN_MASK;

  // send request enables from either channel mode bit
  assign rts_a_on = chan_a_mode_first_b7 | chan_a_mode_second_b5;
  assign rts_b_on = chan_b_mode_first_b7 | chan_b_mode_second_b5;

  // pin source choice
  always @* begin
    pin_kind = {8{`OPFM_DRV_LATCH}};
    pin_alt = 8'h00;
    // pins 0 and 1 follow the mode bits only
    if (rts_a_on) begin
      pin_kind[1:0] = `OPFM_DRV_PUSH;
      pin_alt[0] = chan_a_send_request_n;
    end
    if (rts_b_on) begin
      pin_kind[3:2] = `OPFM_DRV_PUSH;
      pin_alt[1] = chan_b_send_request_n;
    end
    // pin 2 source field
    case (fsel_eff[`OPFM_FSEL_P2_HI:`OPFM_FSEL_P2_LO])
      `OPFM_SRC_LATCH: begin
        pin_kind[5:4] = `OPFM_DRV_LATCH;
      end
      `OPFM_SRC_ALT1: begin
        pin_kind[5:4] = `OPFM_DRV_PUSH;
        pin_alt[2] = chan_a_tx_clock_16x;
      end
      `OPFM_SRC_ALT2: begin
        pin_kind[5:4] = `OPFM_DRV_PUSH;
        pin_alt[2] = chan_a_tx_bit_clock;
      end
      `OPFM_SRC_ALT3: begin
        pin_kind[5:4] = `OPFM_DRV_PUSH;
        pin_alt[2] = chan_a_rx_bit_clock;
      end
      default: begin
        pin_kind[5:4] = `OPFM_DRV_LATCH;
      end
    endcase
    // pin 3 source field
    case (fsel_eff[`OPFM_FSEL_P3_HI:`OPFM_FSEL_P3_LO])
      `OPFM_SRC_LATCH: begin
        pin_kind[7:6] = `OPFM_DRV_LATCH;
      end
      `OPFM_SRC_ALT1: begin
        pin_kind[7:6] = `OPFM_DRV_OPEN;
        pin_alt[3] = ctr_timer_ready;
      end
      `OPFM_SRC_ALT2: begin
        pin_kind[7:6] = `OPFM_DRV_PUSH;
        pin_alt[3] = chan_b_tx_bit_clock;
      end
      `OPFM_SRC_ALT3: begin
        pin_kind[7:6] = `OPFM_DRV_PUSH;
        pin_alt[3] = chan_b_rx_bit_clock;
      end
      default: begin
        pin_kind[7:6] = `OPFM_DRV_LATCH;
      end
    endcase
    // single-bit status selections, all open-drain
    if (fsel_eff[`OPFM_FSEL_P4]) begin
      pin_kind[9:8] = `OPFM_DRV_OPEN;
      pin_alt[4] = chan_a_rx_ready_or_full;
    end
    if (fsel_eff[`OPFM_FSEL_P5]) begin
      pin_kind[11:10] = `OPFM_DRV_OPEN;
      pin_alt[5] = chan_b_rx_ready_or_full;
    end
    if (fsel_eff[`OPFM_FSEL_P6]) begin
      pin_kind[13:12] = `OPFM_DRV_OPEN;
      pin_alt[6] = chan_a_tx_ready;
    end
    if (fsel_eff[`OPFM_FSEL_P7]) begin
      pin_kind[15:14] = `OPFM_DRV_OPEN;
      pin_alt[7] = chan_b_tx_ready;
    end
  end

  // one driver per pin
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      opfm_pin_drive u_drive (
        .pclk(pclk),
        .presetn(presetn),
        .drive_kind(pin_kind[2*gi+1:2*gi]),
        .latch_bit(output_pin_latch_reg[gi]),
        .alt_bit(pin_alt[gi]),
        .pin_exists(PIN_MASK[gi]),
        .pin_out(output_pin[gi]),
        .pin_oe(output_pin_oe[gi])
      );
    end
  endgenerate

  // read mux; write-only registers read as zero
  always @* begin
    rdata_next = 32'h00000000;
    case (reg_ofs)
      `OPFM_LATCH_OFS: begin
        rdata_next = {24'h000000, output_pin_latch_reg};
      end
      `OPFM_PIN_OFS: begin
        rdata_next = {16'h0000, output_pin_oe, output_pin};
      end
      `OPFM_SRC_OFS: begin
        rdata_next = {30'h00000000, rts_b_on, rts_a_on};
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  // read data is captured in the setup phase and held through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (bus_setup && !pwrite) begin
      prdata <= rdata_next;
    end
  end

endmodule

//--- verification/opfm_mux_properties.sv
// assertion checker for the output port function mux
`timescale 1ns/1ps
module opfm_mux_properties #(
  parameter ADDR_W = 8,
  parameter REDUCED_PINS = 0
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  // sources
  input wire chan_a_send_request_n,
  input wire chan_a_mode_first_b7,
  input wire chan_a_tx_ready,
  input wire chan_b_tx_ready,
  input wire chan_a_rx_ready_or_full,
  input wire chan_b_rx_ready_or_full,
  input wire chan_a_tx_clock_16x,
  input wire chan_b_tx_bit_clock,
  input wire ctr_timer_ready,
  // pins
  input wire [7:0] output_pin,
  input wire [7:0] output_pin_oe
);
  reg [7:0] fsel_reg;
  // the reduced variant ignores function select writes
  wire wr_fsel = psel && penable && pwrite && paddr[7:0] == 8'h00 && REDUCED_PINS == 0;
  // shadow of the write-only function select
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fsel_reg <= 8'h00;
    else if (wr_fsel)
      fsel_reg <= pwdata[7:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_P7: assert property (fsel_reg[7] |=>
    !output_pin[7] && output_pin_oe[7] == $past(chan_b_tx_ready)) else $error("pin7 bad");
  AST_P6: assert property (fsel_reg[6] |=>
    !output_pin[6] && output_pin_oe[6] == $past(chan_a_tx_ready)) else $error("pin6 bad");
  AST_P4: assert property (fsel_reg[4] |=>
    output_pin_oe[4] == $past(chan_a_rx_ready_or_full)) else $error("pin4 bad");
  AST_P5: assert property (fsel_reg[5] |=>
    !output_pin[5] && output_pin_oe[5] == $past(chan_b_rx_ready_or_full)) else $error("pin5 bad");
  AST_P3CTR: assert property (fsel_reg[3:2] == 2'h1 |=>
    !output_pin[3] && output_pin_oe[3] == $past(ctr_timer_ready)) else $error("pin3 bad");
  AST_P3CLK: assert property (fsel_reg[3:2] == 2'h2 |=>
    output_pin[3] == $past(chan_b_tx_bit_clock) && output_pin_oe[3]) else $error("pin3 clk");
  AST_P2: assert property (fsel_reg[1:0] == 2'h1 |=>
    output_pin[2] == $past(chan_a_tx_clock_16x) && output_pin_oe[2]) else $error("pin2 bad");
  AST_P0: assert property (chan_a_mode_first_b7 |=>
    output_pin[0] == $past(chan_a_send_request_n) && output_pin_oe[0]) else $error("pin0 bad");
  AST_SLVERR: assert property (psel && penable && paddr[7:0] > 8'h14 |-> pslverr)
    else $error("no slave error");
  AST_SMALL: assert property (REDUCED_PINS != 0 |=>
    output_pin_oe[7:2] == 6'h00 && output_pin[7:2] == 6'h00) else $error("small pins driven");
  // main scenarios reached
  cover property (fsel_reg[7] && chan_b_tx_ready);
  cover property (fsel_reg[3:2] == 2'h2);
  cover property (pslverr);
endmodule
bind opfm_mux opfm_mux_properties #(.ADDR_W(ADDR_W), .REDUCED_PINS(REDUCED_PINS))
  u_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pslverr, .chan_a_send_request_n,
  .chan_a_mode_first_b7, .chan_a_tx_ready, .chan_b_tx_ready, .chan_a_rx_ready_or_full,
  .chan_b_rx_ready_or_full,
  .chan_a_tx_clock_16x, .chan_b_tx_bit_clock, .ctr_timer_ready, .output_pin,
  .output_pin_oe);

//--- verification/opfm_board.sv
// board side pull-ups that resolve the pins to wire levels
`timescale 1ns/1ps
module opfm_board (
  // pins from the device
  input wire [7:0] pin,
  input wire [7:0] pin_oe,
  // resolved wire levels
  output wire [7:0] line
);
  // released open-drain pins idle high through the pull-up
  assign line = (pin & pin_oe) | ~pin_oe;
endmodule

//--- verification/opfm_mux_tb.sv
// self-checking bench for the output port function mux
`timescale 1ns/1ps
module opfm_mux_tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  reg [7:0] paddr = 8'h00, rd;
  reg [31:0] pwdata = 32'h00000000;
  reg [15:0] s = 16'h0000;
  integer mismatches = 0, checks = 0, i;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [7:0] pin, oe, line;
  wire [7:0] pin_s, oe_s;
  localparam [15:0] IDX = 16'hB3C4;
  localparam [3:0] E3 = 4'h7, E2 = 4'hB;
  // clock
  always #2.5 pclk = ~pclk;
  opfm_mux dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_a_send_request_n(s[0]), .chan_a_mode_first_b7(s[1]),
    .chan_a_mode_second_b5(s[2]), .chan_a_tx_ready(s[3]), .chan_a_rx_ready_or_full(s[4]),
    .chan_a_tx_clock_16x(s[5]), .chan_a_tx_bit_clock(s[6]), .chan_a_rx_bit_clock(s[7]),
    .chan_b_send_request_n(s[8]), .chan_b_mode_first_b7(s[9]), .chan_b_mode_second_b5(s[10]),
    .chan_b_tx_ready(s[11]), .chan_b_rx_ready_or_full(s[12]), .chan_b_tx_bit_clock(s[13]),
    .chan_b_rx_bit_clock(s[14]), .ctr_timer_ready(s[15]), .output_pin(pin),
    .output_pin_oe(oe));
  opfm_board board (.pin(pin), .pin_oe(oe), .line(line));
  // reduced-pin variant on the same bus and sources
  opfm_mux #(.REDUCED_PINS(1)) dut_small (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(), .chan_a_send_request_n(s[0]), .chan_a_mode_first_b7(s[1]),
    .chan_a_mode_second_b5(s[2]), .chan_a_tx_ready(s[3]), .chan_a_rx_ready_or_full(s[4]),
    .chan_a_tx_clock_16x(s[5]), .chan_a_tx_bit_clock(s[6]), .chan_a_rx_bit_clock(s[7]),
    .chan_b_send_request_n(s[8]), .chan_b_mode_first_b7(s[9]), .chan_b_mode_second_b5(s[10]),
    .chan_b_tx_ready(s[11]), .chan_b_rx_ready_or_full(s[12]), .chan_b_tx_bit_clock(s[13]),
    .chan_b_rx_bit_clock(s[14]), .ctr_timer_ready(s[15]), .output_pin(pin_s),
    .output_pin_oe(oe_s));
  task chk(input [7:0] seen, input [7:0] exp, input [63:0] nm);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one apb transfer; returns after the pins had an edge to follow it
  task apb(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
      #1;
    end
  endtask
  // new source levels, then two edges; the pins follow them on the first
  task drive(input [15:0] v);
    begin
      @(posedge pclk);
      s <= v;
      repeat (2) @(posedge pclk);
      #1;
    end
  endtask
  task t_latch;
    begin
      chk(line, 8'hFF, "rstline");
      chk(oe, 8'hFF, "rstoe");
      chk(oe_s, 8'h03, "rstsm");
      apb(1'h1, 8'h04, 8'h0F);
      chk(line, 8'hF0, "set");
      apb(1'h1, 8'h04, 8'hF0);
      chk(line, 8'h00, "set2");
      apb(1'h1, 8'h08, 8'hF0);
      chk(line, 8'hF0, "clr");
      apb(1'h0, 8'h0C, 8'h00);
      chk(rd, 8'h0F, "latch");
      $display("end latch");
    end
  endtask
  task t_status;
    begin
      apb(1'h1, 8'h04, 8'hF0);
      apb(1'h1, 8'h00, 8'hF0);
      chk(line, 8'hF0, "odrel");
      for (i = 0; i < 4; i = i + 1) begin
        drive(16'h0001 << IDX[i*4 +: 4]);
        chk(line, {~(4'h1 << i), 4'h0}, "status");
      end
      drive(16'h0000);
      apb(1'h1, 8'h08, 8'hFF);
      apb(1'h1, 8'h00, 8'h00);
      chk(line, 8'hFF, "back");
      $display("end status");
    end
  endtask
  task t_pin32;
    begin
      drive(16'h20A0);
      for (i = 0; i < 4; i = i + 1) begin
        apb(1'h1, 8'h00, 8'h05 * i[7:0]);
        chk(line, {4'hF, E3[i], E2[i], 2'h3}, "p32");
        chk({7'h00, oe[3]}, {7'h00, i != 1}, "oe3");
      end
      apb(1'h1, 8'h00, 8'h00);
      $display("end pin32");
    end
  endtask
  task t_rts;
    begin
      apb(1'h1, 8'h00, 8'hFF);
      apb(1'h1, 8'h04, 8'h03);
      drive(16'h0502);
      chk(line, 8'hF2, "rts");
      chk(pin_s, 8'h02, "rtssm");
      apb(1'h0, 8'h14, 8'h00);
      chk(rd, 8'h03, "rtsen");
      apb(1'h0, 8'h10, 8'h00);
      chk(rd, 8'h02, "pinlvl");
      drive(16'h0201);
      chk(line, 8'hF0, "rts2");
      apb(1'h0, 8'h14, 8'h00);
      chk(rd, 8'h02, "rtsen2");
      drive(16'h0000);
      apb(1'h1, 8'h08, 8'h03);
      apb(1'h1, 8'h00, 8'h00);
      apb(1'h1, 8'h18, 8'hFF);
      chk({7'h00, err}, 8'h01, "slverr");
      chk(line, 8'hFF, "nowr");
      $display("end rts");
    end
  endtask
  // reduced variant keeps only pins 0 and 1 and masks the latch commands
  task t_small;
    begin
      apb(1'h1, 8'h04, 8'hFC);
      chk(pin_s, 8'h03, "smset");
      chk(oe_s, 8'h03, "smoe");
      chk(line, 8'h03, "bigset");
      apb(1'h1, 8'h04, 8'h03);
      chk(pin_s, 8'h00, "smset2");
      apb(1'h1, 8'h08, 8'hFF);
      chk(pin_s, 8'h03, "smclr");
      chk(line, 8'hFF, "bigclr");
      $display("end small");
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    #1;
    t_latch;
    t_status;
    t_pin32;
    t_rts;
    t_small;
    stop_test;
  end
  // watchdog
  initial begin
    #5000;
    mismatches = mismatches + 1;
    stop_test;
  end
endmodule
